/* rtl/hwm_sr_defines.svh */
// named offsets, indexes, bit positions and timing figures of the status readout
`ifndef HWM_SR_DEFINES_SVH
`define HWM_SR_DEFINES_SVH

// avalon byte addresses
`define HWM_SR_ADDR_BANK      5'h00
`define HWM_SR_ADDR_INDEX     5'h04
`define HWM_SR_ADDR_DATA      5'h08
`define HWM_SR_ADDR_CTRL      5'h0c
`define HWM_SR_ADDR_AUXTEMP   5'h10
`define HWM_SR_CTRL_BATT_EN   0

// monitor banks
`define HWM_SR_BANK_FOUR      3'h4
`define HWM_SR_BANK_FIVE      3'h5

// bank 4 indexes
`define HWM_SR_IDX_AUX_OFFSET 8'h56
`define HWM_SR_IDX_STATUS_ONE 8'h59
`define HWM_SR_IDX_STATUS_TWO 8'h5a
`define HWM_SR_IDX_STATUS_THR 8'h5b

// bank 5 indexes
`define HWM_SR_IDX_SB_READ    8'h50
`define HWM_SR_IDX_BAT_READ   8'h51
`define HWM_SR_IDX_V4_READ    8'h52
`define HWM_SR_IDX_FAN_READ   8'h53
`define HWM_SR_IDX_SB_HI      8'h54
`define HWM_SR_IDX_SB_LO      8'h55
`define HWM_SR_IDX_BAT_HI     8'h56
`define HWM_SR_IDX_BAT_LO     8'h57
`define HWM_SR_IDX_V4_HI      8'h58
`define HWM_SR_IDX_V4_LO      8'h59
`define HWM_SR_IDX_FAN_LIMIT  8'h5c

// status one bit positions
`define HWM_SR_S1_CPU_FAN0    7
`define HWM_SR_S1_SYS_FAN     6
`define HWM_SR_S1_CPU_TEMP    5
`define HWM_SR_S1_SYS_TEMP    4
`define HWM_SR_S1_MAIN_3V3    3
`define HWM_SR_S1_ANALOG      2
`define HWM_SR_S1_VOLT_IN_ZERO        1
`define HWM_SR_S1_CORE        0
// status two bit positions
`define HWM_SR_S2_CPU_WARN    7
`define HWM_SR_S2_SYS_WARN    6
`define HWM_SR_S2_AUX_TEMP    5
`define HWM_SR_S2_CASE_OPEN   4
`define HWM_SR_S2_AUX_FAN0    3
`define HWM_SR_S2_CPU_FAN1    2
`define HWM_SR_S2_FAN1_WARN   1
`define HWM_SR_S2_VOLT_IN_ONE        0
// status three bit positions
`define HWM_SR_S3_AUX_FAN1    7
`define HWM_SR_S3_VOLT_IN_TWO        5
`define HWM_SR_S3_VOLT_IN_THREE        4
`define HWM_SR_S3_VOLT_IN_FOUR        3
`define HWM_SR_S3_AUX_WARN    2
`define HWM_SR_S3_BATTERY     1
`define HWM_SR_S3_STANDBY     0

// reset values
`define HWM_SR_BYTE_RESET     8'h00
`define HWM_SR_WORD_RESET     32'h0000_0000

// timing
`define HWM_SR_CLK_HZ         100000000
`define HWM_SR_WARN_TIME_S    180

`endif

/* rtl/hwm_sr_pkg.sv */
// types shared by the status readout modules
package hwm_sr_pkg;

	typedef enum logic [3:0]
	{
		HWM_LOC_NONE      = 4'b0000,
		HWM_LOC_AUX_OFS   = 4'b0001,
		HWM_LOC_ST_ONE    = 4'b0010,
		HWM_LOC_ST_TWO    = 4'b0011,
		HWM_LOC_ST_THR    = 4'b0100,
		HWM_LOC_SB_READ   = 4'b0101,
		HWM_LOC_BAT_READ  = 4'b0110,
		HWM_LOC_V4_READ   = 4'b0111,
		HWM_LOC_FAN_READ  = 4'b1000,
		HWM_LOC_SB_HI     = 4'b1001,
		HWM_LOC_SB_LO     = 4'b1010,
		HWM_LOC_BAT_HI    = 4'b1011,
		HWM_LOC_BAT_LO    = 4'b1100,
		HWM_LOC_V4_HI     = 4'b1101,
		HWM_LOC_V4_LO     = 4'b1110,
		HWM_LOC_FAN_LIMIT = 4'b1111
	} hwm_sr_loc_t;

	// fan counts over their limits, judged by the fan counters
	typedef struct packed
	{
		logic cpu_fan_zero_tach;
		logic system_fan_tach;
		logic aux_fan_zero_tach;
		logic cpu_fan_one_tach;
	} hwm_sr_fan_t;

	// rails outside their windows, judged by the main value bank
	typedef struct packed
	{
		logic main_3v3_rail;
		logic analog_supply_rail;
		logic volt_in_zero;
		logic cpu_core_rail;
		logic volt_in_one;
		logic volt_in_two;
		logic volt_in_three;
	} hwm_sr_volt_t;

	// per temperature channel: above over-temperature, below hysteresis
	typedef struct packed
	{
		logic over;
		logic below_hyst;
	} hwm_sr_temp_t;

	// per fan-control channel: thermal cruise, full speed, above target
	typedef struct packed
	{
		logic cruise;
		logic full_speed;
		logic above_target;
	} hwm_sr_cruise_t;

	typedef struct packed
	{
		logic [63:0] count;
		logic        flag;
	} hwm_sr_warn_state_t;

	typedef struct packed
	{
		logic [2:0]  bank;
		logic [7:0]  index;
		logic        batt_en;
		logic [7:0]  aux_offset;
		logic [7:0]  sb_hi;
		logic [7:0]  sb_lo;
		logic [7:0]  bat_hi;
		logic [7:0]  bat_lo;
		logic [7:0]  v4_hi;
		logic [7:0]  v4_lo;
		logic [7:0]  fan_limit;
		logic [7:0]  sb_rd;
		logic [7:0]  bat_rd;
		logic [7:0]  v4_rd;
		logic [7:0]  fan_rd;
		logic [2:0]  hyst;
		logic        case_latch;
		logic [1:0]  case_sync;
		logic [7:0]  st_one;
		logic [7:0]  st_two;
		logic [7:0]  st_three;
		logic        ack;
		logic        waiting;
		logic [31:0] rdata;
		logic [7:0]  aux_rep;
	} hwm_sr_state_t;

endpackage

/* rtl/hwm_sr_warn.sv */
// fan-control warning timer for one channel
`include "hwm_sr_defines.svh"

module hwm_sr_warn
#(
	parameter longint unsigned WARN_CYCLES = 64'(`HWM_SR_WARN_TIME_S) * 64'(`HWM_SR_CLK_HZ)
)
(
	input  wire logic                    mclk,
	input  wire logic                    reset,
	input  wire hwm_sr_pkg::hwm_sr_cruise_t cond,
	output logic                         warn
);

	hwm_sr_pkg::hwm_sr_warn_state_t state;
	hwm_sr_pkg::hwm_sr_warn_state_t next_state;

	always_comb
	begin
		next_state = state;
		// any break in the condition restarts the full period
		if (cond.cruise && cond.full_speed && cond.above_target)
		begin
			if (state.count >= WARN_CYCLES - 64'd1)
				next_state.flag = 1'b1;
			else
				next_state.count = state.count + 64'd1;
		end
		else
		begin
			next_state.count = 64'd0;
			next_state.flag  = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			state <= '0;
		else
			state <= next_state;
	end

	assign warn = state.flag;

endmodule

/* rtl/hwm_sr_window.sv */
// limit window compare for one rail reading
module hwm_sr_window
(
	input  wire logic       enable,
	input  wire logic [7:0] value,
	input  wire logic [7:0] high_limit,
	input  wire logic [7:0] low_limit,
	output logic            outside
);

	// a disabled rail never reports, its reading is not trusted
	assign outside = enable && ((value > high_limit) || (value < low_limit));

endmodule

/* rtl/hwm_status_readout.sv */
// hardware monitor status registers and second value bank behind avalon-mm
//
// Functional notes
// - aux temperature reported as measured value plus bank 4 offset byte.
// - status one bit 7 reads 1 while cpu fan 0 count over limit.
// - status one bit 6 reads 1 while system fan count over limit.
// - cpu and system temperature bits set over limit, clear below hysteresis.
// - status one bits 3..0 flag four rails outside their limits.
// - three status registers read-only at 59h-5Bh bank 4, reset zero.
// - cpu and system warnings after 3 minutes above target at full speed.
// - status two bit 1 warns for cpu fan 1 selected temperature.
// - status three bit 2 warns for aux temperature likewise.
// - aux temperature bit sets over limit, clears below hysteresis.
// - case open bit latches once intrusion detected.
// - status two bits 3,2 flag aux fan 0 and cpu fan 1 counts.
// - status two bit 0 flags voltage input 1 outside limits.
// - status three bit 7 flags aux fan 1 count; bit 6 reserved.
// - status three bits 5,4,3 flag voltage inputs 2,3,4.
// - status three bits 1,0 flag battery and standby rails.
// - bank 5 50h-53h hold standby, battery, input 4, aux fan 1 count.
// - battery reading invalid unless battery monitor enable bit set.
// - bank 5 5Ch holds aux fan 1 count limit in clock ticks.
//
// The Avalon-MM register port was left to the implementer.
`include "hwm_sr_defines.svh"

module hwm_status_readout
#(
	parameter longint unsigned WARN_CYCLES =
		64'(`HWM_SR_WARN_TIME_S) * 64'(`HWM_SR_CLK_HZ)
)
(
	input  wire logic                          mclk,
	input  wire logic                          reset,
	input  wire logic [4:0]                    avs_address,
	input  wire logic                          avs_read,
	input  wire logic                          avs_write,
	input  wire logic [31:0]                   avs_writedata,
	input  wire logic [3:0]                    avs_byteenable,
	output logic      [31:0]                   avs_readdata,
	output logic                               avs_waitrequest,
	input  wire logic                          sample_valid,
	input  wire logic [7:0]                    standby_rail,
	input  wire logic [7:0]                    battery_rail,
	input  wire logic [7:0]                    volt_in_four,
	input  wire logic [7:0]                    aux_fan_one_tach,
	input  wire logic [7:0]                    aux_temp_input,
	input  wire hwm_sr_pkg::hwm_sr_fan_t       fan_over,
	input  wire hwm_sr_pkg::hwm_sr_volt_t      volt_outside,
	input  wire hwm_sr_pkg::hwm_sr_temp_t      cpu_temp_input,
	input  wire hwm_sr_pkg::hwm_sr_temp_t      system_temp_input,
	input  wire hwm_sr_pkg::hwm_sr_temp_t      aux_temp_limit,
	input  wire hwm_sr_pkg::hwm_sr_cruise_t    cpu_cruise,
	input  wire hwm_sr_pkg::hwm_sr_cruise_t    system_cruise,
	input  wire hwm_sr_pkg::hwm_sr_cruise_t    fan1_cruise,
	input  wire hwm_sr_pkg::hwm_sr_cruise_t    aux_cruise,
	input  wire logic                          case_open_pin,
	output logic      [7:0]                    aux_temp_reading,
	output logic                               battery_monitor_enable
);

	////////////////////////////////////////////////////////////////////////////
	// location decode

	function automatic hwm_sr_pkg::hwm_sr_loc_t locate(input logic [2:0] bank,
		input logic [7:0] index);
		hwm_sr_pkg::hwm_sr_loc_t loc;
		loc = hwm_sr_pkg::HWM_LOC_NONE;
		if (bank == `HWM_SR_BANK_FOUR)
		begin
			case (index)
				`HWM_SR_IDX_AUX_OFFSET: loc = hwm_sr_pkg::HWM_LOC_AUX_OFS;
				`HWM_SR_IDX_STATUS_ONE: loc = hwm_sr_pkg::HWM_LOC_ST_ONE;
				`HWM_SR_IDX_STATUS_TWO: loc = hwm_sr_pkg::HWM_LOC_ST_TWO;
				`HWM_SR_IDX_STATUS_THR: loc = hwm_sr_pkg::HWM_LOC_ST_THR;
				default:                loc = hwm_sr_pkg::HWM_LOC_NONE;
			endcase
		end
		else if (bank == `HWM_SR_BANK_FIVE)
		begin
			case (index)
				`HWM_SR_IDX_SB_READ:   loc = hwm_sr_pkg::HWM_LOC_SB_READ;
				`HWM_SR_IDX_BAT_READ:  loc = hwm_sr_pkg::HWM_LOC_BAT_READ;
				`HWM_SR_IDX_V4_READ:   loc = hwm_sr_pkg::HWM_LOC_V4_READ;
				`HWM_SR_IDX_FAN_READ:  loc = hwm_sr_pkg::HWM_LOC_FAN_READ;
				`HWM_SR_IDX_SB_HI:     loc = hwm_sr_pkg::HWM_LOC_SB_HI;
				`HWM_SR_IDX_SB_LO:     loc = hwm_sr_pkg::HWM_LOC_SB_LO;
				`HWM_SR_IDX_BAT_HI:    loc = hwm_sr_pkg::HWM_LOC_BAT_HI;
				`HWM_SR_IDX_BAT_LO:    loc = hwm_sr_pkg::HWM_LOC_BAT_LO;
				`HWM_SR_IDX_V4_HI:     loc = hwm_sr_pkg::HWM_LOC_V4_HI;
				`HWM_SR_IDX_V4_LO:     loc = hwm_sr_pkg::HWM_LOC_V4_LO;
				`HWM_SR_IDX_FAN_LIMIT: loc = hwm_sr_pkg::HWM_LOC_FAN_LIMIT;
				default:               loc = hwm_sr_pkg::HWM_LOC_NONE;
			endcase
		end
		return loc;
	endfunction

	hwm_sr_pkg::hwm_sr_state_t state;
	hwm_sr_pkg::hwm_sr_state_t next_state;

	////////////////////////////////////////////////////////////////////////////
	// rail windows and hysteresis

	logic [2:0]  rail_outside;
	logic [2:0]  rail_enable;
	logic [23:0] rail_value;
	logic [23:0] rail_high;
	logic [23:0] rail_low;
	logic [2:0]  temp_over;
	logic [2:0]  temp_below;
	logic [3:0]  warn;

	// index 0 standby, 1 battery, 2 input 4
	assign rail_enable = {1'b1, state.batt_en, 1'b1};
	assign rail_value  = {state.v4_rd, state.bat_rd, state.sb_rd};
	assign rail_high   = {state.v4_hi, state.bat_hi, state.sb_hi};
	assign rail_low    = {state.v4_lo, state.bat_lo, state.sb_lo};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_rail
			hwm_sr_window u_window
			(
				.enable     (rail_enable[gi]),
				.value      (rail_value[gi*8 +: 8]),
				.high_limit (rail_high[gi*8 +: 8]),
				.low_limit  (rail_low[gi*8 +: 8]),
				.outside    (rail_outside[gi])
			);
		end
	endgenerate

	// index 0 cpu, 1 system, 2 aux
	assign temp_over  = {aux_temp_limit.over, system_temp_input.over,
		cpu_temp_input.over};
	assign temp_below = {aux_temp_limit.below_hyst, system_temp_input.below_hyst,
		cpu_temp_input.below_hyst};

	////////////////////////////////////////////////////////////////////////////
	// fan-control warning timers

	hwm_sr_pkg::hwm_sr_cruise_t cruise [4];
	assign cruise[0] = cpu_cruise;
	assign cruise[1] = system_cruise;
	assign cruise[2] = fan1_cruise;
	assign cruise[3] = aux_cruise;

	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_warn
			hwm_sr_warn
			#(
				.WARN_CYCLES (WARN_CYCLES)
			)
			u_warn
			(
				.mclk  (mclk),
				.reset (reset),
				.cond  (cruise[gi]),
				.warn  (warn[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// next state

	hwm_sr_pkg::hwm_sr_loc_t loc;
	logic                    wr_now;
	logic [7:0]              wbyte;
	logic [7:0]              data_rd;

	assign loc    = locate(state.bank, state.index);
	assign wr_now = avs_write && state.ack && avs_byteenable[0];
	assign wbyte  = avs_writedata[7:0];

	always_comb
	begin
		data_rd = `HWM_SR_BYTE_RESET;
		case (loc)
			hwm_sr_pkg::HWM_LOC_AUX_OFS:   data_rd = state.aux_offset;
			hwm_sr_pkg::HWM_LOC_ST_ONE:    data_rd = state.st_one;
			hwm_sr_pkg::HWM_LOC_ST_TWO:    data_rd = state.st_two;
			hwm_sr_pkg::HWM_LOC_ST_THR:    data_rd = state.st_three;
			hwm_sr_pkg::HWM_LOC_SB_READ:   data_rd = state.sb_rd;
			hwm_sr_pkg::HWM_LOC_BAT_READ:  data_rd = state.bat_rd;
			hwm_sr_pkg::HWM_LOC_V4_READ:   data_rd = state.v4_rd;
			hwm_sr_pkg::HWM_LOC_FAN_READ:  data_rd = state.fan_rd;
			hwm_sr_pkg::HWM_LOC_SB_HI:     data_rd = state.sb_hi;
			hwm_sr_pkg::HWM_LOC_SB_LO:     data_rd = state.sb_lo;
			hwm_sr_pkg::HWM_LOC_BAT_HI:    data_rd = state.bat_hi;
			hwm_sr_pkg::HWM_LOC_BAT_LO:    data_rd = state.bat_lo;
			hwm_sr_pkg::HWM_LOC_V4_HI:     data_rd = state.v4_hi;
			hwm_sr_pkg::HWM_LOC_V4_LO:     data_rd = state.v4_lo;
			hwm_sr_pkg::HWM_LOC_FAN_LIMIT: data_rd = state.fan_limit;
			default:                       data_rd = `HWM_SR_BYTE_RESET;
		endcase
	end

	always_comb
	begin
		next_state = state;

		// bus handshake: one wait cycle, then waitrequest low for one cycle
		next_state.ack = (avs_read || avs_write) && !state.ack;
		// own flop so the waitrequest port needs no inverter after the register
		next_state.waiting = !next_state.ack;
		if ((avs_read || avs_write) && !state.ack)
		begin
			next_state.rdata = `HWM_SR_WORD_RESET;
			case (avs_address)
				`HWM_SR_ADDR_BANK:    next_state.rdata[2:0] = state.bank;
				`HWM_SR_ADDR_INDEX:   next_state.rdata[7:0] = state.index;
				`HWM_SR_ADDR_DATA:    next_state.rdata[7:0] = data_rd;
				`HWM_SR_ADDR_CTRL:
					next_state.rdata[`HWM_SR_CTRL_BATT_EN] = state.batt_en;
				`HWM_SR_ADDR_AUXTEMP: next_state.rdata[7:0] = state.aux_rep;
				default:              next_state.rdata = `HWM_SR_WORD_RESET;
			endcase
		end

		// writes commit on the edge that sees waitrequest low
		if (wr_now)
		begin
			case (avs_address)
				`HWM_SR_ADDR_BANK:  next_state.bank = wbyte[2:0];
				`HWM_SR_ADDR_INDEX: next_state.index = wbyte;
				`HWM_SR_ADDR_CTRL:
					next_state.batt_en = wbyte[`HWM_SR_CTRL_BATT_EN];
				`HWM_SR_ADDR_DATA:
				begin
					// status and readings are read-only, writes there drop
					case (loc)
						hwm_sr_pkg::HWM_LOC_AUX_OFS:   next_state.aux_offset = wbyte;
						hwm_sr_pkg::HWM_LOC_SB_HI:     next_state.sb_hi = wbyte;
						hwm_sr_pkg::HWM_LOC_SB_LO:     next_state.sb_lo = wbyte;
						hwm_sr_pkg::HWM_LOC_BAT_HI:    next_state.bat_hi = wbyte;
						hwm_sr_pkg::HWM_LOC_BAT_LO:    next_state.bat_lo = wbyte;
						hwm_sr_pkg::HWM_LOC_V4_HI:     next_state.v4_hi = wbyte;
						hwm_sr_pkg::HWM_LOC_V4_LO:     next_state.v4_lo = wbyte;
						hwm_sr_pkg::HWM_LOC_FAN_LIMIT: next_state.fan_limit = wbyte;
						default:                       next_state.bank = state.bank;
					endcase
				end
				default: next_state.bank = state.bank;
			endcase
		end

		// readings captured together so a read never mixes two samples
		if (sample_valid)
		begin
			next_state.sb_rd  = standby_rail;
			next_state.bat_rd = battery_rail;
			next_state.v4_rd  = volt_in_four;
			next_state.fan_rd = aux_fan_one_tach;
		end

		// offset sum wraps at 8 bits like the sensor byte
		next_state.aux_rep = 8'(aux_temp_input + state.aux_offset);

		for (int i = 0; i < 3; i++)
		begin
			if (temp_over[i])
				next_state.hyst[i] = 1'b1;
			else if (temp_below[i])
				next_state.hyst[i] = 1'b0;
		end

		next_state.case_sync = {state.case_sync[0], case_open_pin};
		// no clear path: only reset releases the intrusion latch
		if (state.case_sync[1])
			next_state.case_latch = 1'b1;

		next_state.st_one[`HWM_SR_S1_CPU_FAN0] = fan_over.cpu_fan_zero_tach;
		next_state.st_one[`HWM_SR_S1_SYS_FAN]  = fan_over.system_fan_tach;
		next_state.st_one[`HWM_SR_S1_CPU_TEMP] = state.hyst[0];
		next_state.st_one[`HWM_SR_S1_SYS_TEMP] = state.hyst[1];
		next_state.st_one[`HWM_SR_S1_MAIN_3V3] = volt_outside.main_3v3_rail;
		next_state.st_one[`HWM_SR_S1_ANALOG]   = volt_outside.analog_supply_rail;
		next_state.st_one[`HWM_SR_S1_VOLT_IN_ZERO]     = volt_outside.volt_in_zero;
		next_state.st_one[`HWM_SR_S1_CORE]     = volt_outside.cpu_core_rail;

		next_state.st_two[`HWM_SR_S2_CPU_WARN]  = warn[0];
		next_state.st_two[`HWM_SR_S2_SYS_WARN]  = warn[1];
		next_state.st_two[`HWM_SR_S2_AUX_TEMP]  = state.hyst[2];
		next_state.st_two[`HWM_SR_S2_CASE_OPEN] = state.case_latch;
		next_state.st_two[`HWM_SR_S2_AUX_FAN0]  = fan_over.aux_fan_zero_tach;
		next_state.st_two[`HWM_SR_S2_CPU_FAN1]  = fan_over.cpu_fan_one_tach;
		next_state.st_two[`HWM_SR_S2_FAN1_WARN] = warn[2];
		next_state.st_two[`HWM_SR_S2_VOLT_IN_ONE]      = volt_outside.volt_in_one;

		next_state.st_three = `HWM_SR_BYTE_RESET;
		// higher count means a slower fan, so over the limit is too slow
		next_state.st_three[`HWM_SR_S3_AUX_FAN1] = state.fan_rd > state.fan_limit;
		next_state.st_three[`HWM_SR_S3_VOLT_IN_TWO]     = volt_outside.volt_in_two;
		next_state.st_three[`HWM_SR_S3_VOLT_IN_THREE]     = volt_outside.volt_in_three;
		next_state.st_three[`HWM_SR_S3_VOLT_IN_FOUR]     = rail_outside[2];
		next_state.st_three[`HWM_SR_S3_AUX_WARN] = warn[3];
		next_state.st_three[`HWM_SR_S3_BATTERY]  = rail_outside[1];
		next_state.st_three[`HWM_SR_S3_STANDBY]  = rail_outside[0];
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			state <= '{waiting: 1'b1, default: '0};
		else
			state <= next_state;
	end

	assign avs_readdata           = state.rdata;
	assign avs_waitrequest        = state.waiting;
	assign aux_temp_reading       = state.aux_rep;
	assign battery_monitor_enable = state.batt_en;

endmodule

/* tb/hwm_sr_assertions.sv */
// concurrent checks on the status readout ports
module hwm_sr_assertions
(
	input wire logic        mclk,
	input wire logic        reset,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  aux_temp_input,
	input wire logic [7:0]  aux_temp_reading,
	input wire logic        battery_monitor_enable
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);

	logic st;
	logic rq;
	// a write lands only on the edge that sees waitrequest low
	assign st = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign rq = avs_read && !avs_waitrequest;

	////////////////////////////////////////////////////////////////////////
	wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	take_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	ack_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	upper_zero_a: assert property (rq |-> avs_readdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	unmapped_rd_a: assert property (rq && avs_address > 5'h10 |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	rd_hold_a: assert property (avs_waitrequest && !avs_read && !avs_write |=> $stable(avs_readdata))
		else $error("read data moved while idle");
	aux_read_a: assert property (rq && avs_address == 5'h10 && $stable(aux_temp_reading)
		|-> avs_readdata[7:0] == aux_temp_reading)
		else $error("aux reading port and register differ");
	// the offset is hidden, so only its constancy between writes is checked
	aux_offset_a: assert property (!$past(reset) && !$past(reset, 2) && !$past(st)
		&& !$past(st, 2) |-> 8'(aux_temp_reading - $past(aux_temp_input))
		== 8'($past(aux_temp_reading) - $past(aux_temp_input, 2)))
		else $error("aux offset drifted without a write");
	batt_en_a: assert property (st && avs_address == 5'h0c
		|-> ##2 battery_monitor_enable == $past(avs_writedata[0], 2))
		else $error("battery enable does not follow write");
	ctrl_read_a: assert property (rq && avs_address == 5'h0c && $stable(battery_monitor_enable)
		|-> avs_readdata == {31'h0000_0000, battery_monitor_enable})
		else $error("control readback differs from enable");

	cover property (st && avs_address == 5'h0c);
	cover property (rq && avs_address == 5'h10);
	cover property ($rose(battery_monitor_enable));
endmodule

bind hwm_status_readout hwm_sr_assertions u_chk
(
	.mclk,
	.reset,
	.avs_address,
	.avs_read,
	.avs_write,
	.avs_writedata,
	.avs_byteenable,
	.avs_readdata,
	.avs_waitrequest,
	.aux_temp_input,
	.aux_temp_reading,
	.battery_monitor_enable
);

/* tb/tb_hwm_status_readout.sv */
// self-checking bench for the status readout block
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_hwm_status_readout;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      mclk;
	logic                      reset;
	logic [4:0]                avs_address;
	logic                      avs_read;
	logic                      avs_write;
	logic [31:0]               avs_writedata;
	logic [3:0]                avs_byteenable;
	logic [31:0]               avs_readdata;
	logic                      avs_waitrequest;
	logic                      sample_valid;
	logic [7:0]                standby_rail;
	logic [7:0]                battery_rail;
	logic [7:0]                volt_in_four;
	logic [7:0]                aux_fan_one_tach;
	logic [7:0]                aux_temp_input;
	hwm_sr_pkg::hwm_sr_fan_t    fan_over;
	hwm_sr_pkg::hwm_sr_volt_t   volt_outside;
	hwm_sr_pkg::hwm_sr_temp_t   cpu_temp_input;
	hwm_sr_pkg::hwm_sr_temp_t   system_temp_input;
	hwm_sr_pkg::hwm_sr_temp_t   aux_temp_limit;
	hwm_sr_pkg::hwm_sr_cruise_t cpu_cruise;
	hwm_sr_pkg::hwm_sr_cruise_t system_cruise;
	hwm_sr_pkg::hwm_sr_cruise_t fan1_cruise;
	hwm_sr_pkg::hwm_sr_cruise_t aux_cruise;
	logic                      case_open_pin;
	logic [7:0]                aux_temp_reading;
	logic                      battery_monitor_enable;
	int                        miscompares;
	int                        compares;

	// short warning period keeps the run brief
	hwm_status_readout #(.WARN_CYCLES(20)) dut
	(
		.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_valid,
		.standby_rail, .battery_rail, .volt_in_four, .aux_fan_one_tach,
		.aux_temp_input, .fan_over, .volt_outside, .cpu_temp_input,
		.system_temp_input, .aux_temp_limit, .cpu_cruise, .system_cruise,
		.fan1_cruise, .aux_cruise, .case_open_pin, .aux_temp_reading,
		.battery_monitor_enable
	);

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("miscompares=%0d compares=%0d", miscompares, compares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one avalon access; held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
		begin
			n++;
			if (n > 20)
			begin
				miscompares++;
				conclude();
			end
			@(posedge mclk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h00_0000, d}, q);
	endtask

	task automatic rc(input logic [4:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		`CHK(q, {24'h00_0000, e});
	endtask

	task automatic ri(input logic [2:0] b, input logic [7:0] i, input logic [7:0] e);
		wr(5'h00, {5'h00, b});
		wr(5'h04, i);
		rc(5'h08, e);
	endtask

	task automatic wi(input logic [2:0] b, input logic [7:0] i, input logic [7:0] d);
		wr(5'h00, {5'h00, b});
		wr(5'h04, i);
		wr(5'h08, d);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_zero();
		for (int i = 0; i < 3; i++)
			ri(3'h4, 8'(8'h59 + i), 8'h00);
		wi(3'h4, 8'h59, 8'hff);
		ri(3'h4, 8'h59, 8'h00);
		ri(3'h5, 8'h5a, 8'h00);
		rc(5'h14, 8'h00);
	endtask

	task automatic t_status();
		fan_over <= 4'ha;
		volt_outside <= 7'h55;
		cpu_temp_input <= 2'h2;
		ri(3'h4, 8'h59, 8'haa);
		ri(3'h4, 8'h5a, 8'h09);
		ri(3'h4, 8'h5b, 8'h10);
		// cpu temperature left between its limits must stay flagged
		fan_over <= 4'h5;
		volt_outside <= 7'h2a;
		cpu_temp_input <= 2'h0;
		system_temp_input <= 2'h2;
		aux_temp_limit <= 2'h2;
		ri(3'h4, 8'h59, 8'h75);
		ri(3'h4, 8'h5a, 8'h24);
		ri(3'h4, 8'h5b, 8'h20);
		fan_over <= 4'h0;
		volt_outside <= 7'h00;
		cpu_temp_input <= 2'h1;
		system_temp_input <= 2'h1;
		aux_temp_limit <= 2'h1;
		ri(3'h4, 8'h59, 8'h00);
		ri(3'h4, 8'h5a, 8'h00);
	endtask

	task automatic t_warn();
		cpu_cruise <= 3'h7;
		system_cruise <= 3'h7;
		fan1_cruise <= 3'h7;
		aux_cruise <= 3'h7;
		ri(3'h4, 8'h5a, 8'h00);
		repeat (30) @(posedge mclk);
		ri(3'h4, 8'h5a, 8'hc2);
		ri(3'h4, 8'h5b, 8'h04);
		cpu_cruise <= 3'h5;
		aux_cruise <= 3'h3;
		ri(3'h4, 8'h5a, 8'h42);
		ri(3'h4, 8'h5b, 8'h00);
		cpu_cruise <= 3'h0;
		system_cruise <= 3'h0;
		fan1_cruise <= 3'h0;
		aux_cruise <= 3'h0;
	endtask

	task automatic t_case();
		case_open_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		case_open_pin <= 1'b0;
		ri(3'h4, 8'h5a, 8'h10);
	endtask

	// mid-run reset must clear the intrusion latch read back in status two
	task automatic t_reset();
		ri(3'h4, 8'h5b, 8'h00);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		ri(3'h4, 8'h5a, 8'h00);
	endtask

	task automatic t_rails();
		logic [7:0] rd [4];
		rd = '{8'h80, 8'h10, 8'h1f, 8'h40};
		for (int i = 0; i < 6; i++)
			wi(3'h5, 8'(8'h54 + i), i[0] ? 8'h20 : 8'h80);
		wi(3'h5, 8'h5c, 8'h40);
		wi(3'h4, 8'h56, 8'h05);
		ri(3'h5, 8'h56, 8'h80);
		ri(3'h5, 8'h5c, 8'h40);
		standby_rail <= 8'h90;
		battery_rail <= 8'h10;
		volt_in_four <= 8'h50;
		aux_fan_one_tach <= 8'h41;
		aux_temp_input <= 8'hfe;
		sample_valid <= 1'b1;
		@(posedge mclk);
		sample_valid <= 1'b0;
		ri(3'h4, 8'h5b, 8'h81);
		ri(3'h4, 8'h56, 8'h05);
		`CHK(aux_temp_reading, 8'h03);
		rc(5'h10, 8'h03);
		wr(5'h0c, 8'h01);
		rc(5'h0c, 8'h01);
		`CHK(battery_monitor_enable, 1'b1);
		// a write with byte lane 0 disabled must leave the enable alone
		avs_byteenable <= 4'h0;
		wr(5'h0c, 8'h00);
		avs_byteenable <= 4'hf;
		rc(5'h0c, 8'h01);
		ri(3'h4, 8'h5b, 8'h83);
		// values on the limits count as inside
		standby_rail <= 8'h80;
		volt_in_four <= 8'h1f;
		aux_fan_one_tach <= 8'h40;
		sample_valid <= 1'b1;
		@(posedge mclk);
		sample_valid <= 1'b0;
		ri(3'h4, 8'h5b, 8'h0a);
		for (int i = 0; i < 4; i++)
			ri(3'h5, 8'(8'h50 + i), rd[i]);
		wi(3'h5, 8'h50, 8'h55);
		ri(3'h5, 8'h50, 8'h80);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		miscompares = 0;
		compares = 0;
		reset = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hf;
		sample_valid = 1'b0;
		standby_rail = 8'h00;
		battery_rail = 8'h00;
		volt_in_four = 8'h00;
		aux_fan_one_tach = 8'h00;
		aux_temp_input = 8'h00;
		fan_over = 4'h0;
		volt_outside = 7'h00;
		cpu_temp_input = 2'h0;
		system_temp_input = 2'h0;
		aux_temp_limit = 2'h0;
		cpu_cruise = 3'h0;
		system_cruise = 3'h0;
		fan1_cruise = 3'h0;
		aux_cruise = 3'h0;
		case_open_pin = 1'b0;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		t_zero();
		t_status();
		t_warn();
		t_case();
		t_reset();
		t_rails();
		conclude();
	end
endmodule
